//--- rtl/clock_alarm_status_interrupt.sv
// Purpose: Status, sticky flags, masks and interrupt of the clock alarm block
// Assumes: Register port from the serial management slave on core_clk;
//          alarm levels and address pins come from other domains
// Notes:   One write strobe per cycle; reads return data one cycle later
`timescale 1ns/1ps
`include "alarm_map.svh"
module clock_alarm_status_interrupt
(
  input  wire logic                core_clk,
  input  wire logic                srst,
  input  wire logic                addr_select_pin_hi,
  input  wire logic                addr_select_pin_lo,
  input  wire logic                device_calibrating,
  input  wire logic                ref_signal_missing,
  input  wire logic                bus_timeout,
  input  wire logic [1:0]          input_signal_loss,
  input  wire logic [1:0]          input_freq_out_of_range,
  input  wire logic                pll_unlocked,
  input  wire logic                pll_holdover,
  input  wire logic                pll_cal_busy,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire alarm_pkg::reg_addr_t reg_addr,
  input  wire alarm_pkg::reg_byte_t reg_wdata,
  output alarm_pkg::reg_byte_t     reg_rdata,
  output logic                     reg_rvalid,
  output logic [6:0]               slave_address,
  output logic                     soft_reset_pulse,
  output logic                     interrupt_out_n
);
  import alarm_pkg::*;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  localparam int LIVE_W = 12;
  logic [LIVE_W-1:0] live_async;
  logic [LIVE_W-1:0] live_sync;

  assign live_async = {addr_select_pin_hi, addr_select_pin_lo,
                       device_calibrating, ref_signal_missing, bus_timeout,
                       input_signal_loss, input_freq_out_of_range,
                       pll_unlocked, pll_holdover, pll_cal_busy};

  level_sync #(.WIDTH(LIVE_W)) u_sync
  (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in (live_async),
    .sync_out (live_sync)
  );

  logic [1:0] addr_pins_s;
  logic       calibrating_s;
  logic       ref_missing_s;
  logic       timeout_s;
  logic [1:0] loss_s;
  logic [1:0] freq_s;
  logic       unlocked_s;
  logic       holdover_s;
  logic       cal_busy_s;

  assign addr_pins_s   = live_sync[11:10];
  assign calibrating_s = live_sync[9];
  assign ref_missing_s = live_sync[8];
  assign timeout_s     = live_sync[7];
  assign loss_s        = live_sync[6:5];
  assign freq_s        = live_sync[4:3];
  assign unlocked_s    = live_sync[2];
  assign holdover_s    = live_sync[1];
  assign cal_busy_s    = live_sync[0];

  // ************************************************************
  // Live status bytes
  // ************************************************************
  reg_byte_t internal_live;
  reg_byte_t input_alarm_live;
  reg_byte_t pll_lock_live;
  reg_byte_t pll_cal_live;

  always_comb
  begin
    internal_live = `ZERO_BYTE;
    internal_live[`BIT_CALIBRATING] = calibrating_s;
    internal_live[`BIT_REF_MISSING] = ref_missing_s;
    internal_live[`BIT_BUS_TIMEOUT] = timeout_s;
  end

  always_comb
  begin
    input_alarm_live = `ZERO_BYTE;
    input_alarm_live[`BIT_LOSS_BASE +: 2] = loss_s;
    input_alarm_live[`BIT_FREQ_BASE +: 2] = freq_s;
  end

  always_comb
  begin
    pll_lock_live = `ZERO_BYTE;
    pll_lock_live[`BIT_PLL_UNLOCKED] = unlocked_s;
    pll_lock_live[`BIT_PLL_HOLDOVER] = holdover_s;
  end

  always_comb
  begin
    pll_cal_live = `ZERO_BYTE;
    pll_cal_live[`BIT_PLL_CAL_BUSY] = cal_busy_s;
  end

  // ************************************************************
  // Write decode
  // ************************************************************
  logic wr_slave;
  logic wr_int_sticky;
  logic wr_in_sticky;
  logic wr_lock_sticky;
  logic wr_cal_sticky;
  logic wr_int_mask;
  logic wr_in_mask;
  logic wr_lock_mask;
  logic wr_cal_mask;
  logic wr_soft_reset;

  assign wr_slave       = reg_wr && (reg_addr == `REG_SLAVE_ADDR_UPPER);
  assign wr_int_sticky  = reg_wr && (reg_addr == `REG_INTERNAL_STICKY);
  assign wr_in_sticky   = reg_wr && (reg_addr == `REG_INPUT_ALARM_STICKY);
  assign wr_lock_sticky = reg_wr && (reg_addr == `REG_PLL_LOCK_HOLD_STICKY);
  assign wr_cal_sticky  = reg_wr && (reg_addr == `REG_PLL_CAL_STICKY);
  assign wr_int_mask    = reg_wr && (reg_addr == `REG_INTERNAL_MASKS);
  assign wr_in_mask     = reg_wr && (reg_addr == `REG_INPUT_ALARM_MASKS);
  assign wr_lock_mask   = reg_wr && (reg_addr == `REG_PLL_LOCK_HOLD_MASKS);
  assign wr_cal_mask    = reg_wr && (reg_addr == `REG_PLL_CAL_MASK);
  assign wr_soft_reset  = reg_wr && (reg_addr == `REG_SOFT_RESET);

  // ************************************************************
  // Mask and address registers
  // ************************************************************
  logic [4:0] slave_upper_reg;
  reg_byte_t  int_mask_reg;
  reg_byte_t  in_mask_reg;
  reg_byte_t  lock_mask_reg;
  reg_byte_t  cal_mask_reg;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      slave_upper_reg <= `SLAVE_ADDR_UPPER_RESET;
      int_mask_reg    <= `MASK_RESET;
      in_mask_reg     <= `MASK_RESET;
      lock_mask_reg   <= `MASK_RESET;
      cal_mask_reg    <= `MASK_RESET;
    end
    else
    begin
      if (wr_slave)
        slave_upper_reg <= reg_wdata[`SLAVE_ADDR_FIELD_LSB +: 5];
      if (wr_int_mask)
        int_mask_reg <= reg_wdata & `INTERNAL_BITS_MASK;
      if (wr_in_mask)
        in_mask_reg <= reg_wdata & `INPUT_ALARM_BITS_MASK;
      if (wr_lock_mask)
        lock_mask_reg <= reg_wdata & `PLL_LOCK_HOLD_BITS_MASK;
      if (wr_cal_mask)
        cal_mask_reg <= reg_wdata & `PLL_CAL_BITS_MASK;
    end
  end

  // Upper bits from software, lowest two follow the pins
  always_ff @(posedge core_clk)
  begin
    if (srst)
      slave_address <= 7'h00;
    else
      slave_address <= {slave_upper_reg, addr_pins_s};
  end

  // ************************************************************
  // Sticky flags, one instance per implemented bit
  // ************************************************************
  localparam int NFLAG = 32;
  logic [NFLAG-1:0] flag_live;
  logic [NFLAG-1:0] flag_clear;
  logic [NFLAG-1:0] flag_mask;
  logic [NFLAG-1:0] flag_val;
  logic [NFLAG-1:0] flag_irq;
  logic [7:0]       clr_int;
  logic [7:0]       clr_in;
  logic [7:0]       clr_lock;
  logic [7:0]       clr_cal;

  // Zero written to a bit clears it
  assign clr_int  = wr_int_sticky  ? ~reg_wdata : 8'h00;
  assign clr_in   = wr_in_sticky   ? ~reg_wdata : 8'h00;
  assign clr_lock = wr_lock_sticky ? ~reg_wdata : 8'h00;
  assign clr_cal  = wr_cal_sticky  ? ~reg_wdata : 8'h00;

  assign flag_live  = {pll_cal_live, pll_lock_live, input_alarm_live, internal_live};
  assign flag_clear = {clr_cal, clr_lock, clr_in, clr_int};
  assign flag_mask  = {cal_mask_reg, lock_mask_reg, in_mask_reg, int_mask_reg};
  // Constant, so the generate below can leave unused bits without a flop
  localparam logic [NFLAG-1:0] FLAG_IMPL = {`PLL_CAL_BITS_MASK, `PLL_LOCK_HOLD_BITS_MASK,
                                             `INPUT_ALARM_BITS_MASK, `INTERNAL_BITS_MASK};

  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++)
    begin : g_flag
      if (FLAG_IMPL[gi])
      begin : g_impl
        sticky_flag u_flag
        (
          .core_clk  (core_clk),
          .srst      (srst),
          .live      (flag_live[gi]),
          .clear_req (flag_clear[gi]),
          .mask      (flag_mask[gi]),
          .flag      (flag_val[gi]),
          .irq_req   (flag_irq[gi])
        );
      end
      else
      begin : g_none
        assign flag_val[gi] = 1'b0;
        assign flag_irq[gi] = 1'b0;
      end
    end
  endgenerate

  reg_byte_t int_sticky;
  reg_byte_t in_sticky;
  reg_byte_t lock_sticky;
  reg_byte_t cal_sticky;

  assign int_sticky  = flag_val[7:0];
  assign in_sticky   = flag_val[15:8];
  assign lock_sticky = flag_val[23:16];
  assign cal_sticky  = flag_val[31:24];

  // Pin driven low while any unmasked flag stands
  always_ff @(posedge core_clk)
  begin
    if (srst)
      interrupt_out_n <= 1'b1;
    else
      interrupt_out_n <= ~(|flag_irq);
  end

  // ************************************************************
  // Soft reset
  // ************************************************************
  soft_reset_state_t sr_state_reg;
  soft_reset_state_t sr_state_next;

  // Pulse is one cycle; bit reads back as zero since it clears itself
  always_comb
  begin
    sr_state_next = sr_state_reg;
    case (sr_state_reg)
      SR_IDLE:
        if (wr_soft_reset && reg_wdata[`SOFT_RESET_BIT])
          sr_state_next = SR_PULSE;
      SR_PULSE:
        sr_state_next = SR_WAIT;
      SR_WAIT:
        sr_state_next = SR_IDLE;
      default:
        sr_state_next = SR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sr_state_reg     <= SR_IDLE;
      soft_reset_pulse <= 1'b0;
    end
    else
    begin
      sr_state_reg     <= sr_state_next;
      soft_reset_pulse <= (sr_state_next == SR_PULSE);
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  reg_byte_t rd_mux;

  always_comb
  begin
    if (reg_addr == `REG_SLAVE_ADDR_UPPER)
      rd_mux = {1'b0, slave_upper_reg, 2'b00};
    else if (reg_addr == `REG_INTERNAL_STATUS)
      rd_mux = internal_live;
    else if (reg_addr == `REG_INPUT_ALARM_STATUS)
      rd_mux = input_alarm_live;
    else if (reg_addr == `REG_PLL_LOCK_HOLD_STATUS)
      rd_mux = pll_lock_live;
    else if (reg_addr == `REG_PLL_CAL_STATUS)
      rd_mux = pll_cal_live;
    else if (reg_addr == `REG_INTERNAL_STICKY)
      rd_mux = int_sticky;
    else if (reg_addr == `REG_INPUT_ALARM_STICKY)
      rd_mux = in_sticky;
    else if (reg_addr == `REG_PLL_LOCK_HOLD_STICKY)
      rd_mux = lock_sticky;
    else if (reg_addr == `REG_PLL_CAL_STICKY)
      rd_mux = cal_sticky;
    else if (reg_addr == `REG_INTERNAL_MASKS)
      rd_mux = int_mask_reg;
    else if (reg_addr == `REG_INPUT_ALARM_MASKS)
      rd_mux = in_mask_reg;
    else if (reg_addr == `REG_PLL_LOCK_HOLD_MASKS)
      rd_mux = lock_mask_reg;
    else if (reg_addr == `REG_PLL_CAL_MASK)
      rd_mux = cal_mask_reg;
    else
      rd_mux = `ZERO_BYTE;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      reg_rdata  <= `ZERO_BYTE;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rd_mux;
    end
  end
endmodule

//--- rtl/alarm_map.svh
// Purpose: Register offsets, field positions and reset values of the alarm block
// Assumes: 8-bit registers on page 0, addressed by a 16-bit register address
// Notes:   Only definitions here
// Operation
// - Slave address: field bits 6:2, pins low
// - Internal status bit 0: calibrating
// - Internal status bit 1: reference signal missing
// - Internal status bit 5: bus timeout
// - Alarm status 1:0 live per-input loss
// - Alarm status 5:4 live per-input frequency
// - Input 0 bits 0/4, input 1 bits 1/5
// - PLL status bit 1 live unlock
// - PLL status bit 5 live holdover
// - Calibration status bit 5 live busy
// - Sticky internal flags, cleared by writing zero
// - Sticky per-input flags, cleared by writing zero
// - Sticky unlock/holdover flags, write zero clears
// - Sticky calibration busy flag, write zero clears
// - Internal masks block matching sticky flags
// - Mask bit 1 blocks reference-loss interrupt
// - Per-input masks block matching flags
// - Masks 1 and 5 block unlock/holdover
// - Mask bit 5 blocks calibration busy
// - Soft reset bit 0 self-clears; zero ignored
`ifndef ALARM_MAP_SVH
`define ALARM_MAP_SVH

`define REG_SLAVE_ADDR_UPPER     16'h000b
`define REG_INTERNAL_STATUS      16'h000c
`define REG_INPUT_ALARM_STATUS   16'h000d
`define REG_PLL_LOCK_HOLD_STATUS 16'h000e
`define REG_PLL_CAL_STATUS       16'h000f
`define REG_INTERNAL_STICKY      16'h0011
`define REG_INPUT_ALARM_STICKY   16'h0012
`define REG_PLL_LOCK_HOLD_STICKY 16'h0013
`define REG_PLL_CAL_STICKY       16'h0014
`define REG_INTERNAL_MASKS       16'h0017
`define REG_INPUT_ALARM_MASKS    16'h0018
`define REG_PLL_LOCK_HOLD_MASKS  16'h0019
`define REG_PLL_CAL_MASK         16'h001a
`define REG_SOFT_RESET           16'h001c

// Implemented bits per register
`define SLAVE_ADDR_FIELD_MASK    8'h7c
`define SLAVE_ADDR_FIELD_LSB     2
`define INTERNAL_BITS_MASK       8'h23
`define INPUT_ALARM_BITS_MASK    8'h33
`define PLL_LOCK_HOLD_BITS_MASK  8'h22
`define PLL_CAL_BITS_MASK        8'h20
`define SOFT_RESET_BIT           0

`define BIT_CALIBRATING          0
`define BIT_REF_MISSING          1
`define BIT_BUS_TIMEOUT          5
`define BIT_LOSS_BASE            0
`define BIT_FREQ_BASE            4
`define BIT_PLL_UNLOCKED         1
`define BIT_PLL_HOLDOVER         5
`define BIT_PLL_CAL_BUSY         5

`define SLAVE_ADDR_UPPER_RESET   5'h1a
`define MASK_RESET               8'h00
`define ZERO_BYTE                8'h00

`endif

//--- rtl/alarm_pkg.sv
// Purpose: Types shared by the alarm block
// Assumes: Nothing beyond the map header
// Notes:   Constants live in alarm_map.svh
package alarm_pkg;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [15:0] reg_addr_t;
  typedef enum logic [1:0]
  {
    SR_IDLE  = 2'b00,
    SR_PULSE = 2'b01,
    SR_WAIT  = 2'b10
  } soft_reset_state_t;
endpackage

//--- rtl/level_sync.sv
// Purpose: Two-stage synchroniser for a group of levels
// Assumes: Inputs come from outside the core clock domain
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module level_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

//--- rtl/sticky_flag.sv
// Purpose: One sticky flag with its mask and interrupt request
// Assumes: Live status already in the core clock domain
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/1ps
module sticky_flag
(
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic live,
  input  wire logic clear_req,
  input  wire logic mask,
  output logic      flag,
  output logic      irq_req
);
  logic flag_next;

  // Writing one leaves the flag; a live one always sets
  assign flag_next = live | (flag & ~clear_req);
  // Masked flags stay visible but never reach the pin
  assign irq_req   = flag & ~mask;

  always_ff @(posedge core_clk)
  begin
    if (srst)
      flag <= 1'b0;
    else
      flag <= flag_next;
  end
endmodule

//--- testbench/clock_alarm_status_interrupt_asserts.sv
// Purpose: Port-level checks of the clock alarm block
// Assumes: Reads answer one cycle after the strobe
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps
module alarm_port_checks
(
  input wire logic                 core_clk,
  input wire logic                 srst,
  input wire logic                 addr_select_pin_hi,
  input wire logic                 addr_select_pin_lo,
  input wire logic                 device_calibrating,
  input wire logic                 ref_signal_missing,
  input wire logic                 bus_timeout,
  input wire logic [1:0]           input_signal_loss,
  input wire logic [1:0]           input_freq_out_of_range,
  input wire logic                 pll_unlocked,
  input wire logic                 pll_holdover,
  input wire logic                 pll_cal_busy,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire alarm_pkg::reg_addr_t reg_addr,
  input wire alarm_pkg::reg_byte_t reg_wdata,
  input wire alarm_pkg::reg_byte_t reg_rdata,
  input wire logic                 reg_rvalid,
  input wire logic [6:0]           slave_address,
  input wire logic                 soft_reset_pulse,
  input wire logic                 interrupt_out_n
);
  import alarm_pkg::*;
  logic       pulse_d_reg;
  logic [2:0] up_cnt_reg;
  logic       open_w;
  logic       live_any_w;
  logic [1:0] pins_w;
  always_ff @(posedge core_clk)
  begin
    pulse_d_reg <= srst ? 1'b0 : soft_reset_pulse;
    up_cnt_reg  <= srst ? 3'h0 : up_cnt_reg + {2'h0, up_cnt_reg != 3'h7};
  end
  // Requests in the pulse cycle and the cycle after it are left unchecked
  assign open_w     = !soft_reset_pulse && !pulse_d_reg;
  assign pins_w     = {addr_select_pin_hi, addr_select_pin_lo};
  assign live_any_w = device_calibrating | ref_signal_missing | bus_timeout | (|input_signal_loss)
                      | (|input_freq_out_of_range) | pll_unlocked | pll_holdover | pll_cal_busy;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // ****************************************
  // Properties
  // ****************************************
  AST_RD_ANSWER: assert property (reg_rd && open_w |=> reg_rvalid)
    else $error("read strobe not answered");
  AST_RVALID_CAUSE: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without a read");
  AST_UNMAPPED_ZERO: assert property (reg_rd && open_w && (reg_addr == 16'h0010 || reg_addr == 16'h001c)
    |=> reg_rdata == 8'h00) else $error("unmapped or reset register read not zero");
  AST_PULSE_CAUSE: assert property (soft_reset_pulse
    |-> $past(reg_wr && reg_addr == 16'h001c && reg_wdata[0])) else $error("reset pulse without a write of one");
  AST_PULSE_ONE: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("reset pulse longer than a cycle");
  AST_INT_RISE: assert property ($rose(interrupt_out_n) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("interrupt released without a write");
  AST_INT_FALL: assert property ($fell(interrupt_out_n)
    |-> $past(live_any_w, 4) || $past(reg_wr) || $past(reg_wr, 2)) else $error("interrupt without cause");
  AST_ADDR_FIELD: assert property (reg_wr && open_w && reg_addr == 16'h000b ##1 !(reg_wr && reg_addr == 16'h000b)
    |=> slave_address[6:2] == $past(reg_wdata[6:2], 2)) else $error("address field not applied");
  AST_ADDR_PINS: assert property (up_cnt_reg == 3'h7 && $stable(pins_w) && pins_w == $past(pins_w, 2)
    && pins_w == $past(pins_w, 3) && pins_w == $past(pins_w, 4) |-> slave_address[1:0] == pins_w)
    else $error("address low bits differ from pins");
  COV_PULSE: cover property (soft_reset_pulse);
  COV_INT: cover property ($fell(interrupt_out_n));
  COV_READ: cover property (reg_rvalid && reg_rdata != 8'h00);
endmodule
bind clock_alarm_status_interrupt alarm_port_checks chk
(
  .core_clk(core_clk), .srst(srst), .addr_select_pin_hi(addr_select_pin_hi),
  .addr_select_pin_lo(addr_select_pin_lo), .device_calibrating(device_calibrating),
  .ref_signal_missing(ref_signal_missing), .bus_timeout(bus_timeout), .input_signal_loss(input_signal_loss),
  .input_freq_out_of_range(input_freq_out_of_range), .pll_unlocked(pll_unlocked), .pll_holdover(pll_holdover),
  .pll_cal_busy(pll_cal_busy), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .slave_address(slave_address),
  .soft_reset_pulse(soft_reset_pulse), .interrupt_out_n(interrupt_out_n)
);

//--- testbench/host_bus_model.sv
// Purpose: Host side of the register port
// Assumes: Requests launched and released at falling edges
// Notes:   Idle address and data lines flip so stale values never pass
`timescale 1ns/1ps
module host_bus_model
(
  input  wire logic                 core_clk,
  input  wire alarm_pkg::reg_byte_t reg_rdata,
  input  wire logic                 reg_rvalid,
  output logic                      reg_wr,
  output logic                      reg_rd,
  output alarm_pkg::reg_addr_t      reg_addr,
  output alarm_pkg::reg_byte_t      reg_wdata
);
  import alarm_pkg::*;
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 16'h0000;
    reg_wdata = 8'h00;
  end
  // ****************************************
  // Bus cycles
  // ****************************************
  task automatic idle();
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    idle();
  endtask
  // Zero over a set flag clears it, ones leave the others alone
  task automatic clear_bits(input reg_addr_t a, input reg_byte_t bits);
    wr(a, ~bits);
  endtask
  task automatic rd(input reg_addr_t a, output reg_byte_t d);
    int n;
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    idle();
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge core_clk);
      n++;
    end
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule

//--- testbench/clock_alarm_status_interrupt_test.sv
// Purpose: Self-checking bench for the clock alarm block
// Assumes: Host model drives the register port at falling edges
// Notes:   Live alarms are held long enough to cross the synchronisers
`timescale 1ns/1ps
`include "alarm_map.svh"
module clock_alarm_status_interrupt_test;
  import alarm_pkg::*;
  logic        core_clk;
  logic        srst;
  logic [1:0]  pins;
  logic [7:0]  lv [4];
  logic [7:0]  fv [4];
  logic [7:0]  mv [4];
  logic [7:0]  imp [4];
  logic [4:0]  field;
  logic [7:0]  tmp;
  logic        reg_wr;
  logic        reg_rd;
  reg_addr_t   reg_addr;
  reg_byte_t   reg_wdata;
  reg_byte_t   reg_rdata;
  logic        reg_rvalid;
  logic [6:0]  slave_address;
  logic        soft_reset_pulse;
  logic        interrupt_out_n;
  int unsigned seed = 17686;
  int          bad_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  clock_alarm_status_interrupt DUT
  (
    .core_clk(core_clk), .srst(srst), .addr_select_pin_hi(pins[1]), .addr_select_pin_lo(pins[0]),
    .device_calibrating(lv[0][0]), .ref_signal_missing(lv[0][1]), .bus_timeout(lv[0][5]),
    .input_signal_loss(lv[1][1:0]), .input_freq_out_of_range(lv[1][5:4]), .pll_unlocked(lv[2][1]),
    .pll_holdover(lv[2][5]), .pll_cal_busy(lv[3][5]), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .slave_address(slave_address),
    .soft_reset_pulse(soft_reset_pulse), .interrupt_out_n(interrupt_out_n)
  );
  host_bus_model HOST
  (
    .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata)
  );
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      bad_count++;
      results();
    end
  end
  // ****************************************
  // Model and helpers
  // ****************************************
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic reg_byte_t expect_of(input int a);
    if (a >= 12 && a <= 15) return lv[a-12] & imp[a-12];
    if (a >= 17 && a <= 20) return fv[a-17];
    if (a >= 23 && a <= 26) return mv[a-23];
    if (a == 11) return {1'b0, field, 2'b00};
    return 8'h00;
  endfunction
  function automatic logic exp_int();
    logic any;
    any = 1'b0;
    for (int i = 0; i < 4; i++)
      any |= |(fv[i] & ~mv[i]);
    return ~any;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks_done %0d bad_count %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Flags follow live levels once the synchronisers have passed them
  task automatic settle();
    repeat (5) @(negedge core_clk);
    for (int i = 0; i < 4; i++)
      fv[i] |= lv[i] & imp[i];
  endtask
  task automatic put(input int a, input reg_byte_t d);
    if (a >= 17 && a <= 20)
      HOST.clear_bits(a[15:0], ~d);
    else
      HOST.wr(a[15:0], d);
    if (a >= 17 && a <= 20) fv[a-17] &= d | (lv[a-17] & imp[a-17]);
    if (a >= 23 && a <= 26) mv[a-23] = d & imp[a-23];
    if (a == 11) field = d[6:2];
  endtask
  task automatic rd_chk(input int a);
    reg_byte_t d;
    HOST.rd(a[15:0], d);
    check(d, expect_of(a));
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    srst = 1'b1;
    pins = 2'b10;
    field = `SLAVE_ADDR_UPPER_RESET;
    imp = '{`INTERNAL_BITS_MASK, `INPUT_ALARM_BITS_MASK, `PLL_LOCK_HOLD_BITS_MASK, `PLL_CAL_BITS_MASK};
    for (int i = 0; i < 4; i++)
    begin
      lv[i] = 8'h00;
      fv[i] = 8'h00;
      mv[i] = 8'h00;
    end
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    settle();
    for (int a = 11; a <= 28; a++) rd_chk(a);
    check({1'b0, slave_address}, {1'b0, field, pins});
    for (int k = 0; k < 4; k++)
    begin
      put(23 + k, rnd());
      rd_chk(23 + k);
      put(23 + k, 8'h00);
    end
    put(11, rnd());
    tmp = rnd();
    pins = tmp[1:0];
    put(12, 8'hff);
    settle();
    check({1'b0, slave_address}, {1'b0, field, pins});
    rd_chk(11);
    rd_chk(12);
    for (int i = 0; i < 4; i++)
      for (int b = 0; b < 8; b++)
        if (imp[i][b])
        begin
          lv[i][b] = 1'b1;
          settle();
          rd_chk(12 + i);
          rd_chk(17 + i);
          check({7'h0, interrupt_out_n}, {7'h0, exp_int()});
          put(17 + i, 8'hff);
          lv[i][b] = 1'b0;
          settle();
          rd_chk(12 + i);
          rd_chk(17 + i);
          put(17 + i, ~(8'h01 << b));
          settle();
          rd_chk(17 + i);
          check({7'h0, interrupt_out_n}, {7'h0, exp_int()});
          put(23 + i, 8'h01 << b);
          lv[i][b] = 1'b1;
          settle();
          check({7'h0, interrupt_out_n}, {7'h0, exp_int()});
          put(17 + i, 8'h00);
          rd_chk(17 + i);
          put(23 + i, 8'h00);
          lv[i][b] = 1'b0;
          settle();
          check({7'h0, interrupt_out_n}, {7'h0, exp_int()});
          put(17 + i, 8'h00);
          settle();
          check({7'h0, interrupt_out_n}, {7'h0, exp_int()});
        end
    HOST.wr(16'h001c, 8'h01);
    check({7'h0, soft_reset_pulse}, 8'h01);
    @(negedge core_clk);
    check({7'h0, soft_reset_pulse}, 8'h00);
    repeat (3) @(negedge core_clk);
    HOST.wr(16'h001c, 8'h00);
    check({7'h0, soft_reset_pulse}, 8'h00);
    rd_chk(28);
    results();
  end
endmodule
